// File: awdf_pkg.sv
// Constants and helpers shared by the write data channel buffer.
// Notes on behaviour
// R1: Each accepted slave-side beat has its ID, data, strobes, last flag and user field packed into one stored word.
// R2: The master-side ID, data, strobes, last flag and user field are unpacked from the stored word without change.
// R3: The data width is a build-time choice of 8, 16, 32, 64, 128, 256 or 512 bits, the same on both ports.
// R4: There is one strobe bit per data byte, and strobe bit n covers data bits 8n to 8n+7.
// R5: A strobe bit of one marks its byte lane valid and zero marks it not valid, and the block passes them on unchanged.
// R6: The upstream master raises last only on the final beat of a burst, and the block repeats it on that same beat.
// R7: The upstream master gives every data beat the ID of its matching write address transaction.
// R8: The upstream master holds slave-side valid high while it offers a beat and low otherwise.
// R9: The block drives slave-side ready high when it can take a beat and low when it cannot.
// R10: The downstream slave drives master-side ready high when it can take a beat and low otherwise.
// R11: A beat moves only on an edge where valid and ready are both high, ready is low when full, and valid is low when empty.
// R12: Once master-side valid is high, valid and every beat field stay stable until the beat is accepted.
package awdf_pkg;

  localparam int unsigned WDATA_W    = 32;
  localparam int unsigned WID_W      = 4;
  localparam int unsigned WUSER_W    = 1;
  localparam int unsigned LANE_W     = 8;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned PTR_W      = 2;
  localparam int unsigned CNT_W      = 3;
  localparam logic [CNT_W-1:0] CNT_RESET = 3'h0;
  localparam logic [PTR_W-1:0] PTR_RESET = 2'h0;
  localparam logic VALID_RESET = 1'b0;
  localparam logic LAST_RESET  = 1'b0;
  localparam logic ROOM_RESET  = 1'b1;
  localparam logic EMPTY_RESET = 1'b1;

  typedef enum logic [1:0]
  {
    OUT_IDLE = 2'h1,
    OUT_HOLD = 2'h2
  } awdf_out_state_t;

  function automatic bit width_is_legal(input int unsigned w);
    begin
      width_is_legal = (w == 8) || (w == 16) || (w == 32) || (w == 64) ||
                       (w == 128) || (w == 256) || (w == 512);
    end
  endfunction

endpackage

// File: awdf_stream_if.sv
// Valid and ready stream of packed beat words between the buffer's own modules.
`timescale 1ns/1ps
interface awdf_stream_if #(parameter int unsigned WORD_W = 8);
  logic              valid;
  logic              ready;
  logic [WORD_W-1:0] word;

  modport src
  (
    output valid,
    output word,
    input  ready
  );

  modport dst
  (
    input  valid,
    input  word,
    output ready
  );
endinterface

// File: awdf_fifo.sv
// Four word flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module awdf_fifo
  import awdf_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = awdf_pkg::FIFO_DEPTH
)
(
  input  wire logic    clock_in,
  input  wire logic    resetn_in,
  awdf_stream_if.dst   push,
  awdf_stream_if.src   pop
);

  logic [WIDTH-1:0]       store [DEPTH];
  logic [PTR_W-1:0]       wr_ptr;
  logic [PTR_W-1:0]       rd_ptr;
  logic [CNT_W-1:0]       count;
  logic [CNT_W-1:0]       next_count;
  logic                   room;
  logic                   empty;
  logic                   do_write;
  logic                   do_read;

  assign push.ready = room;                 // see R9 see R11
  assign pop.valid  = ~empty;               // see R11
  assign pop.word   = store[rd_ptr];
  assign do_write   = push.valid & room;    // see R11
  assign do_read    = pop.ready & ~empty;   // see R11

  always_comb
  begin
    next_count = count;
    if (do_write && !do_read)
    begin
      next_count = count + 3'h1;
    end
    else if (do_read && !do_write)
    begin
      next_count = count - 3'h1;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (do_write)
    begin
      store[wr_ptr] <= push.word;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wr_ptr <= PTR_RESET;
      rd_ptr <= PTR_RESET;
    end
    else
    begin
      if (do_write)
      begin
        wr_ptr <= wr_ptr + 2'h1;
      end
      if (do_read)
      begin
        rd_ptr <= rd_ptr + 2'h1;
      end
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      count <= CNT_RESET;
      room  <= ROOM_RESET;
      empty <= EMPTY_RESET;
    end
    else
    begin
      count <= next_count;
      room  <= (next_count != CNT_W'(DEPTH));
      empty <= (next_count == CNT_RESET);
    end
  end

endmodule

// File: awdf_top.sv
// Write data channel buffer: slave-side port, four word FIFO, registered master-side port.
`timescale 1ns/1ps
module awdf_top
  import awdf_pkg::*;
#(
  parameter int unsigned DATA_W = awdf_pkg::WDATA_W,
  parameter int unsigned ID_W   = awdf_pkg::WID_W,
  parameter int unsigned USER_W = awdf_pkg::WUSER_W
)
(
  input  wire logic                        clock_in,
  input  wire logic                        resetn_in,
  input  wire logic [ID_W-1:0]             s_axi_wid_in,
  input  wire logic [DATA_W-1:0]           s_axi_wdata_in,
  input  wire logic [DATA_W/LANE_W-1:0]    s_axi_wstrb_in,
  input  wire logic                        s_axi_wlast_in,
  input  wire logic [USER_W-1:0]           s_axi_wuser_in,
  input  wire logic                        s_axi_wvalid_in,
  output logic                             s_axi_wready_out,
  output logic [ID_W-1:0]                  m_axi_wid_out,
  output logic [DATA_W-1:0]                m_axi_wdata_out,
  output logic [DATA_W/LANE_W-1:0]         m_axi_wstrb_out,
  output logic                             m_axi_wlast_out,
  output logic [USER_W-1:0]                m_axi_wuser_out,
  output logic                             m_axi_wvalid_out,
  input  wire logic                        m_axi_wready_in
);

  localparam int unsigned STRB_W = DATA_W / LANE_W;
  localparam int unsigned WORD_W = ID_W + DATA_W + STRB_W + 1 + USER_W;

  // Bit positions of the fields inside a stored word, user field lowest.
  localparam int unsigned USER_LSB = 0;
  localparam int unsigned LAST_POS = USER_LSB + USER_W;
  localparam int unsigned STRB_LSB = LAST_POS + 1;
  localparam int unsigned DATA_LSB = STRB_LSB + STRB_W;
  localparam int unsigned ID_LSB   = DATA_LSB + DATA_W;

  // Stops the build when the data width is not one of the legal ones.
  if (!width_is_legal(DATA_W))
  begin : g_bad_width
    $error("Write data width must be 8, 16, 32, 64, 128, 256 or 512 bits.");
  end

  awdf_stream_if #(.WORD_W(WORD_W)) in_ch ();
  awdf_stream_if #(.WORD_W(WORD_W)) out_ch ();

  awdf_out_state_t        out_state;
  awdf_out_state_t        next_out_state;
  logic [DATA_W-1:0]      lane_data;
  logic [STRB_W-1:0]      lane_strb;
  logic                   stage_free;
  logic                   load;
  logic [ID_W-1:0]        head_id;
  logic [DATA_W-1:0]      head_data;
  logic [STRB_W-1:0]      head_strb;
  logic                   head_last;
  logic [USER_W-1:0]      head_user;

  // Strobe bit n stays beside data bits 8n to 8n+7 through the whole path.
  genvar lane;
  generate
    for (lane = 0; lane < STRB_W; lane++)
    begin : g_lane
      assign lane_data[lane*LANE_W +: LANE_W] = s_axi_wdata_in[lane*LANE_W +: LANE_W]; // see R4
      assign lane_strb[lane] = s_axi_wstrb_in[lane];   // see R4 see R5
    end
  endgenerate

  // Packs the beat fields into one stored word.
  assign in_ch.word  = {s_axi_wid_in, lane_data, lane_strb,
                        s_axi_wlast_in, s_axi_wuser_in};   // see R1 see R3
  assign in_ch.valid = s_axi_wvalid_in;                    // see R8
  assign s_axi_wready_out = in_ch.ready;                   // see R9 see R11

  // Four word buffer between the slave-side port and the output stage.
  awdf_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .push      (in_ch),
    .pop       (out_ch)
  );

  // The output stage takes a new word only when it is empty or its word is being accepted.
  assign stage_free   = ~m_axi_wvalid_out | m_axi_wready_in;   // see R10 see R12
  assign load         = out_ch.valid & stage_free;             // see R12
  assign out_ch.ready = stage_free;                            // see R11

  // The output stage holds a word while one is waiting and goes idle once drained.
  always_comb
  begin
    next_out_state = out_state;
    case (out_state)
      OUT_IDLE:
      begin
        if (out_ch.valid)
        begin
          next_out_state = OUT_HOLD;
        end
      end
      OUT_HOLD:
      begin
        if (m_axi_wready_in && !out_ch.valid)
        begin
          next_out_state = OUT_IDLE;
        end
      end
      default:
      begin
        next_out_state = OUT_IDLE;
      end
    endcase
  end

  // Output stage state.
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      out_state <= OUT_IDLE;
    end
    else
    begin
      out_state <= next_out_state;
    end
  end

  // Master-side valid is high for as long as a word is held.
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      m_axi_wvalid_out <= VALID_RESET;
    end
    else
    begin
      m_axi_wvalid_out <= (next_out_state == OUT_HOLD);   // see R11 see R12
    end
  end

  // Splits the word at the head of the FIFO into its fields.
  assign head_id   = out_ch.word[ID_LSB +: ID_W];       // see R2 see R7
  assign head_last = out_ch.word[LAST_POS];             // see R6
  assign head_user = out_ch.word[USER_LSB +: USER_W];   // see R2

  // Each strobe bit leaves beside the byte that it governs.
  genvar out_lane;
  generate
    for (out_lane = 0; out_lane < STRB_W; out_lane++)
    begin : g_head_lane
      assign head_data[out_lane*LANE_W +: LANE_W] =
        out_ch.word[DATA_LSB + out_lane*LANE_W +: LANE_W];   // see R2 see R4
      assign head_strb[out_lane] = out_ch.word[STRB_LSB + out_lane];   // see R4 see R5
    end
  endgenerate

  // Master-side ID, loaded with each new word and held until it is accepted.
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      m_axi_wid_out <= '0;
    end
    else if (load)
    begin
      m_axi_wid_out <= head_id;   // see R2 see R12
    end
  end

  // Master-side data, loaded with each new word and held until it is accepted.
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      m_axi_wdata_out <= '0;
    end
    else if (load)
    begin
      m_axi_wdata_out <= head_data;   // see R2 see R12
    end
  end

  // Master-side strobes, loaded with each new word and held until it is accepted.
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      m_axi_wstrb_out <= '0;
    end
    else if (load)
    begin
      m_axi_wstrb_out <= head_strb;   // see R5 see R12
    end
  end

  // Master-side last flag, loaded with each new word and held until it is accepted.
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      m_axi_wlast_out <= LAST_RESET;
    end
    else if (load)
    begin
      m_axi_wlast_out <= head_last;   // see R6 see R12
    end
  end

  // Master-side user field, loaded with each new word and held until it is accepted.
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      m_axi_wuser_out <= '0;
    end
    else if (load)
    begin
      m_axi_wuser_out <= head_user;   // see R2 see R12
    end
  end

endmodule

// File: awdf_top_monitor.sv
// Checker of the write data buffer ports.
`timescale 1ns/1ps
module awdf_top_monitor
  import awdf_pkg::*;
#(
  parameter int unsigned DATA_W = 32,
  parameter int unsigned ID_W   = 4,
  parameter int unsigned USER_W = 1
)
(
  input wire logic                     clock_in,
  input wire logic                     resetn_in,
  input wire logic [ID_W-1:0]          s_axi_wid_in,
  input wire logic [DATA_W-1:0]        s_axi_wdata_in,
  input wire logic [DATA_W/LANE_W-1:0] s_axi_wstrb_in,
  input wire logic                     s_axi_wlast_in,
  input wire logic [USER_W-1:0]        s_axi_wuser_in,
  input wire logic                     s_axi_wvalid_in,
  input wire logic                     s_axi_wready_out,
  input wire logic [ID_W-1:0]          m_axi_wid_out,
  input wire logic [DATA_W-1:0]        m_axi_wdata_out,
  input wire logic [DATA_W/LANE_W-1:0] m_axi_wstrb_out,
  input wire logic                     m_axi_wlast_out,
  input wire logic [USER_W-1:0]        m_axi_wuser_out,
  input wire logic                     m_axi_wvalid_out,
  input wire logic                     m_axi_wready_in
);
  logic [2:0] cnt;
  wire logic  take  = s_axi_wvalid_in && s_axi_wready_out;
  wire logic  give  = m_axi_wvalid_out && m_axi_wready_in;
  wire logic  stall = m_axi_wvalid_out && !m_axi_wready_in;
  // Counts the beats held inside the block.
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      cnt <= 3'h0;
    else
      cnt <= cnt + 3'(take) - 3'(give);
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  AST_HOLD_VALID: assert property (stall |=> m_axi_wvalid_out)
    else $error("Valid dropped before accept.");
  AST_HOLD_DATA: assert property (stall |=> $stable({m_axi_wdata_out, m_axi_wstrb_out}))
    else $error("Data changed before accept.");
  AST_HOLD_TAG: assert property (stall |=> $stable({m_axi_wid_out, m_axi_wlast_out, m_axi_wuser_out}))
    else $error("Tag fields changed before accept.");
  AST_FULL_BLOCKS: assert property (cnt == 3'h5 |-> !s_axi_wready_out)
    else $error("Ready high while full.");
  AST_READY_LOW: assert property (!s_axi_wready_out |-> cnt == 3'h5)
    else $error("Ready low with room.");
  AST_READY_ROOM: assert property (cnt < 3'h5 |-> s_axi_wready_out)
    else $error("Ready missing with room.");
  AST_EMPTY_IDLE: assert property (cnt == 3'h0 |-> !m_axi_wvalid_out)
    else $error("Valid high while empty.");
  AST_SHOW_SOON: assert property (take && cnt == 3'h0 |-> ##[1:2] m_axi_wvalid_out)
    else $error("Beat not presented in time.");
endmodule

bind awdf_top awdf_top_monitor #(.DATA_W(DATA_W), .ID_W(ID_W), .USER_W(USER_W)) u_mon (.*);

// File: awdf_sink_model.sv
// Downstream slave model that takes beats at a chosen pace.
`timescale 1ns/1ps
module awdf_sink_model
(
  input  wire logic       clock_in,
  input  wire logic       resetn_in,
  input  wire logic [1:0] mode_in,
  output logic            ready_out
);
  logic tick;
  // Mode 0 always ready, mode 1 every other cycle, mode 2 stalled.
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      tick      <= 1'b0;
      ready_out <= 1'b0;
    end
    else
    begin
      tick      <= !tick;
      ready_out <= (mode_in == 2'h0) || (mode_in == 2'h1 && tick);
    end
  end
endmodule

// File: awdf_tb_top.sv
// Self-checking bench of the write data buffer.
`timescale 1ns/1ps
module awdf_tb_top;
  import awdf_pkg::*;
  localparam int unsigned WW = WID_W + WDATA_W + WDATA_W / LANE_W + 1 + WUSER_W;
  logic                      clk = 1'b0;
  logic                      rstn = 1'b0;
  logic [WID_W-1:0]          wid, mid;
  logic [WDATA_W-1:0]        wdat, mdat;
  logic [WDATA_W/LANE_W-1:0] wstb, mstb;
  logic [WUSER_W-1:0]        wusr, musr;
  logic                      wlst, wvld, wrdy, mlst, mvld, mrdy;
  logic [1:0]                mode;
  logic [WW-1:0]             exp_q[$];
  int                        fails = 0;
  int                        total_checks = 0;
  wire logic [WW-1:0]        mw = {mid, mdat, mstb, mlst, musr};
  always #2.5 clk = !clk;
  awdf_top u_dut (.clock_in(clk), .resetn_in(rstn), .s_axi_wid_in(wid), .s_axi_wdata_in(wdat),
    .s_axi_wstrb_in(wstb), .s_axi_wlast_in(wlst), .s_axi_wuser_in(wusr), .s_axi_wvalid_in(wvld),
    .s_axi_wready_out(wrdy), .m_axi_wid_out(mid), .m_axi_wdata_out(mdat), .m_axi_wstrb_out(mstb),
    .m_axi_wlast_out(mlst), .m_axi_wuser_out(musr), .m_axi_wvalid_out(mvld),
    .m_axi_wready_in(mrdy));
  awdf_sink_model u_sink (.clock_in(clk), .resetn_in(rstn), .mode_in(mode), .ready_out(mrdy));
  task automatic check_word(input logic [WW-1:0] got, input logic [WW-1:0] want);
  begin
    total_checks++;
    if (got !== want)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, want);
    end
  end
  endtask
  task automatic check_flag(input logic got, input logic want);
  begin
    check_word(WW'(got), WW'(want));
  end
  endtask
  // Every accepted output beat must match the oldest beat sent.
  always @(posedge clk)
    if (mvld === 1'b1 && mrdy === 1'b1)
      check_word(mw, exp_q.size() != 0 ? exp_q.pop_front() : 'x);
  task automatic send(input logic [WW-1:0] w);
  begin
    {wid, wdat, wstb, wlst, wusr} <= w;
    wvld <= 1'b1;
    do @(posedge clk); while (wrdy !== 1'b1);
    exp_q.push_back(w);
  end
  endtask
  task automatic drain();
  begin
    wvld <= 1'b0;
    repeat (60) if (exp_q.size() != 0) @(posedge clk);
    @(posedge clk);
    check_flag(exp_q.size() == 0 && mvld === 1'b0, 1'b1);
    check_flag(wrdy, 1'b1);
  end
  endtask
  task automatic t_pass();
  begin
    mode <= 2'h0;
    for (int i = 0; i < 6; i++)
      send({4'h3, 32'ha5a50000 + i, i < 4 ? 4'h1 << i : (i == 4 ? 4'hf : 4'h0),
            i == 5, 1'b1});
    drain();
    $display("t_pass done");
  end
  endtask
  task automatic t_full();
  begin
    mode <= 2'h2;
    for (int i = 0; i < 5; i++)
      send({4'hc, 32'h0f0f0000 + i, 4'h5, 1'b0, 1'b0});
    wvld <= 1'b0;
    repeat (3) @(posedge clk);
    check_flag(wrdy, 1'b0);
    mode <= 2'h1;
    for (int i = 5; i < 13; i++)
      send({4'hc, 32'hc3c30000 + i, 4'ha, i == 12, 1'(i)});
    drain();
    $display("t_full done");
  end
  endtask
  task automatic finish_test();
  begin
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  initial
  begin
    {wid, wdat, wstb, wlst, wusr, wvld, mode} = '0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check_flag(wrdy, 1'b1);
    check_flag(mvld, 1'b0);
    t_pass();
    t_full();
    finish_test();
  end
  // Cuts a hang short well after the tests should have ended.
  initial
  begin
    #20000;
    fails++;
    finish_test();
  end
endmodule
